/* ptc_pkg.sv */
// Package: constants and types for the pump trigger and option control block
package ptc_pkg;
   typedef enum logic [2:0] {
      PTC_TRG_TOGGLE     = 3'h0,
      PTC_TRG_HOLD       = 3'h1,
      PTC_TRG_TOGGLE_REV = 3'h2,
      PTC_TRG_LEVEL      = 3'h3,
      PTC_TRG_START      = 3'h4,
      PTC_TRG_START_REV  = 3'h5,
      PTC_TRG_STOP       = 3'h6,
      PTC_TRG_STOP_REV   = 3'h7
   } ptc_trig_e;

   typedef enum logic {
      PTC_DIR_RECIP = 1'h0,
      PTC_DIR_DUAL  = 1'h1
   } ptc_dirmode_e;

   typedef enum logic [1:0] {
      PTC_RUN_STOP  = 2'h0,
      PTC_RUN_PUMP  = 2'h1,
      PTC_RUN_PAUSE = 2'h2,
      PTC_RUN_DRIP  = 2'h3
   } ptc_run_e;

   typedef enum logic [3:0] {
      PTC_OPT_SLOW    = 4'h0,
      PTC_OPT_DRIP    = 4'h1,
      PTC_OPT_REPEAT  = 4'h2,
      PTC_OPT_DELAY   = 4'h3,
      PTC_OPT_OTHER   = 4'h4,
      PTC_OPT_PFAIL   = 4'h5,
      PTC_OPT_ALARM   = 4'h6,
      PTC_OPT_TRIG    = 4'h7,
      PTC_OPT_DIR     = 4'h8,
      PTC_OPT_MOTOR   = 4'h9,
      PTC_OPT_DONE    = 4'hA
   } ptc_opt_e;

   localparam int  PTC_CLK_HZ        = 100_000_000;
   localparam int  PTC_TENTH_NS      = 100_000_000;
   localparam int  PTC_TENTH_CYC     = PTC_TENTH_NS / (1_000_000_000 / PTC_CLK_HZ);
   localparam int  PTC_SETUP_MS      = 2000;
   localparam int  PTC_SETUP_TENTHS  = PTC_SETUP_MS / 100;
   localparam int  PTC_BEEP_TENTHS   = 3;
   localparam logic [6:0] PTC_DLY_MAX = 7'h63;
   localparam logic [6:0] PTC_DLY_MIN = 7'h01;
   localparam logic [6:0] PTC_SEC_TENTHS = 7'h0A;
   localparam int  PTC_SLOW_STEPS    = 4;
   localparam logic [1:0] PTC_SPEED_FULL = 2'h3;
endpackage

/* ptc_edge_if.sv */
// Interface: synchronized level and edge pulses of one external input
`timescale 1ns/100ps
interface ptc_edge_if;
   logic level;
   logic rise;
   logic fall;
   modport src (output level, output rise, output fall);
   modport dst (input level, input rise, input fall);
endinterface

/* ptc_sync_edge.sv */
// Module: two-stage synchronizer with edge detection
`timescale 1ns/100ps
module ptc_sync_edge (
   input  wire logic  ref_clk,
   input  wire logic  rst,
   input  wire logic  pin,
   ptc_edge_if.src    edge_o
);
   logic meta_q;
   logic sync_q;
   logic last_q;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         meta_q <= 1'h1;
         sync_q <= 1'h1;
         last_q <= 1'h1;
      end else begin
         meta_q <= pin;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign edge_o.level = sync_q;
   assign edge_o.rise  = sync_q & ~last_q;
   assign edge_o.fall  = ~sync_q & last_q;
endmodule

/* ptc_tick.sv */
// Module: tenth-second enable pulse divider
`timescale 1ns/100ps
module ptc_tick #(
   parameter int DIV = ptc_pkg::PTC_TENTH_CYC
) (
   input  wire logic ref_clk,
   input  wire logic rst,
   output logic      tick
);
   logic [$clog2(DIV)-1:0] cnt_q;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
         tick  <= 1'h0;
      end else if (cnt_q == ($clog2(DIV))'(DIV - 1)) begin
         cnt_q <= '0;
         tick  <= 1'h1;
      end else begin
         cnt_q <= cnt_q + 1'b1;
         tick  <= 1'h0;
      end
   end
endmodule

/* ptc_top.sv */
// Module: run control, trigger decode, motor output and setup options
`timescale 1ns/100ps
module ptc_top #(
   parameter int TENTH_CYC = ptc_pkg::PTC_TENTH_CYC,
   parameter int VOL_W     = 16
) (
   input  wire logic                ref_clk,
   input  wire logic                rst,
   input  wire logic                trig_pin,
   input  wire logic                dir_pin,
   input  wire logic                key_start,
   input  wire logic                serial_run,
   input  wire logic                serial_stop,
   input  wire logic                key_any,
   input  wire logic                key_setup,
   input  wire logic                key_arrow,
   input  wire logic                key_nonarrow,
   input  wire logic                power_up,
   input  wire logic                keys_held_at_power,
   input  wire logic                was_running_nv,
   input  wire logic                dispense_mode,
   input  wire logic                volume_done,
   input  wire logic                drip_done,
   input  wire logic                wait_trigger,
   input  wire logic                alarm_cond,
   input  wire logic [VOL_W-1:0]    target_vol,
   input  wire logic [VOL_W-1:0]    dispensed_vol,
   input  wire logic [VOL_W-1:0]    drip_vol,
   input  wire logic                set_wr,
   input  wire logic                set_slow,
   input  wire logic                set_drip,
   input  wire logic                set_repeat,
   input  wire logic [6:0]          set_delay,
   input  wire logic                set_delay_tenths,
   input  wire logic                set_pfail,
   input  wire logic                set_alarm,
   input  wire ptc_pkg::ptc_trig_e  set_trig,
   input  wire ptc_pkg::ptc_dirmode_e set_dir,
   input  wire logic                set_motor_mode,
   output logic                     running,
   output logic                     motor_active,
   output logic                     withdraw,
   output logic                     drip_withdraw,
   output logic [VOL_W-1:0]         next_target,
   output logic [1:0]               speed_level,
   output logic                     restart_first_phase,
   output logic                     restart_last_dispense,
   output logic                     buzzer,
   output ptc_pkg::ptc_opt_e        setup_option,
   output logic                     set_rejected,
   output logic                     slow_down_setting,
   output logic                     drip_en,
   output logic                     repeat_en,
   output logic [6:0]               delay_val,
   output logic                     delay_tenths
);
   import ptc_pkg::*;

   // ----------------------------------------------------------------
   // Input synchronizers and time base
   // ----------------------------------------------------------------
   ptc_edge_if trig_e ();
   ptc_edge_if dir_e ();
   logic tick;

   ptc_sync_edge u_trig (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pin     (trig_pin),
      .edge_o  (trig_e)
   );

   ptc_sync_edge u_dir (
      .ref_clk (ref_clk),
      .rst     (rst),
      .pin     (dir_pin),
      .edge_o  (dir_e)
   );

   ptc_tick #(.DIV(TENTH_CYC)) u_tick (
      .ref_clk (ref_clk),
      .rst     (rst),
      .tick    (tick)
   );

   // ----------------------------------------------------------------
   // Setup option storage
   // ----------------------------------------------------------------
   ptc_trig_e    trig_mode_q;
   ptc_dirmode_e dir_mode_q;
   logic         pfail_q;
   logic         alarm_en_q;
   logic         motor_mode_q;
   ptc_run_e     run_q;
   logic         stopped;

   assign stopped = (run_q == PTC_RUN_STOP);

   function automatic logic delay_ok(input logic [6:0] v);
      delay_ok = (v >= PTC_DLY_MIN) && (v <= PTC_DLY_MAX);
   endfunction

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         slow_down_setting <= 1'h0;
         drip_en           <= 1'h0;
         repeat_en         <= 1'h0;
         delay_val         <= PTC_DLY_MIN;
         delay_tenths      <= 1'h0;
         pfail_q           <= 1'h0;
         alarm_en_q        <= 1'h0;
         trig_mode_q       <= PTC_TRG_TOGGLE;
         dir_mode_q        <= PTC_DIR_RECIP;
         motor_mode_q      <= 1'h0;
         set_rejected      <= 1'h0;
      end else begin
         set_rejected <= set_wr & ~stopped;
         if (set_wr && stopped) begin
            slow_down_setting <= set_slow;
            drip_en           <= set_drip;
            repeat_en         <= set_repeat;
            if (delay_ok(set_delay)) begin
               delay_val    <= set_delay;
               delay_tenths <= set_delay_tenths;
            end
            pfail_q      <= set_pfail;
            alarm_en_q   <= set_alarm;
            trig_mode_q  <= set_trig;
            dir_mode_q   <= set_dir;
            motor_mode_q <= set_motor_mode;
         end
      end
   end

   // ----------------------------------------------------------------
   // Setup menu stepping
   // ----------------------------------------------------------------
   logic [4:0] menu_cnt_q;
   logic       in_menu_q;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         in_menu_q    <= 1'h0;
         menu_cnt_q   <= '0;
         setup_option <= PTC_OPT_SLOW;
      end else if (!stopped) begin
         in_menu_q <= 1'h0;
      end else if (!in_menu_q) begin
         if (key_setup) begin
            in_menu_q    <= 1'h1;
            menu_cnt_q   <= '0;
            setup_option <= PTC_OPT_SLOW;
         end
      end else if (key_arrow) begin
         menu_cnt_q <= '0;
      end else if (key_nonarrow || (tick && menu_cnt_q == 5'(PTC_SETUP_TENTHS - 1))) begin
         menu_cnt_q <= '0;
         if (setup_option == PTC_OPT_DONE) begin
            in_menu_q    <= 1'h0;
            setup_option <= PTC_OPT_SLOW;
         end else if (setup_option == PTC_OPT_REPEAT && !repeat_en) begin
            setup_option <= PTC_OPT_OTHER;
         end else begin
            setup_option <= ptc_opt_e'(setup_option + 4'h1);
         end
      end else if (tick) begin
         menu_cnt_q <= menu_cnt_q + 5'h1;
      end
   end

   // ----------------------------------------------------------------
   // Trigger decode and run control
   // ----------------------------------------------------------------
   logic trg_start;
   logic trg_stop;

   always_comb begin
      trg_start = 1'b0;
      trg_stop  = 1'b0;
      unique case (trig_mode_q)
         PTC_TRG_TOGGLE: begin
            trg_start = trig_e.fall & stopped;
            trg_stop  = trig_e.fall & ~stopped;
         end
         PTC_TRG_TOGGLE_REV: begin
            trg_start = trig_e.rise & stopped;
            trg_stop  = trig_e.rise & ~stopped;
         end
         PTC_TRG_HOLD: begin
            trg_start = trig_e.fall;
            trg_stop  = trig_e.rise;
         end
         PTC_TRG_LEVEL: begin
            trg_start = trig_e.rise;
            trg_stop  = trig_e.fall;
         end
         PTC_TRG_START:     trg_start = trig_e.fall;
         PTC_TRG_START_REV: trg_start = trig_e.rise;
         PTC_TRG_STOP:      trg_stop  = trig_e.fall;
         PTC_TRG_STOP_REV:  trg_stop  = trig_e.rise;
      endcase
   end

   logic toggle_req;
   logic start_req;
   logic stop_req;
   logic auto_start_q;
   logic [6:0] pause_tenths_q;
   logic [3:0] sub_tenths_q;

   assign toggle_req = key_start | serial_run;
   assign start_req  = trg_start | (toggle_req & stopped) | auto_start_q;
   assign stop_req   = trg_stop | serial_stop | (toggle_req & ~stopped);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         run_q          <= PTC_RUN_STOP;
         pause_tenths_q <= '0;
         sub_tenths_q   <= '0;
      end else if (stop_req && !stopped) begin
         run_q <= PTC_RUN_STOP;
      end else if (start_req && stopped) begin
         run_q <= PTC_RUN_PUMP;
      end else begin
         unique case (run_q)
            PTC_RUN_STOP: run_q <= PTC_RUN_STOP;
            PTC_RUN_PUMP: begin
               if (volume_done) begin
                  if (drip_en && !withdraw) begin
                     run_q <= PTC_RUN_DRIP;
                  end else if (repeat_en) begin
                     run_q          <= PTC_RUN_PAUSE;
                     pause_tenths_q <= delay_val;
                     sub_tenths_q   <= delay_tenths ? 4'h0 : 4'(PTC_SEC_TENTHS - 7'h1);
                  end else begin
                     run_q <= PTC_RUN_STOP;
                  end
               end
            end
            PTC_RUN_DRIP: begin
               if (drip_done) begin
                  if (repeat_en) begin
                     run_q          <= PTC_RUN_PAUSE;
                     pause_tenths_q <= delay_val;
                     sub_tenths_q   <= delay_tenths ? 4'h0 : 4'(PTC_SEC_TENTHS - 7'h1);
                  end else begin
                     run_q <= PTC_RUN_STOP;
                  end
               end
            end
            PTC_RUN_PAUSE: begin
               if (tick) begin
                  if (sub_tenths_q != 4'h0) begin
                     sub_tenths_q <= sub_tenths_q - 4'h1;
                  end else if (pause_tenths_q <= PTC_DLY_MIN) begin
                     run_q <= PTC_RUN_PUMP;
                  end else begin
                     pause_tenths_q <= pause_tenths_q - 7'h1;
                     sub_tenths_q   <= delay_tenths ? 4'h0 : 4'(PTC_SEC_TENTHS - 7'h1);
                  end
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Power-failure restart
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         auto_start_q          <= 1'h0;
         restart_first_phase   <= 1'h0;
         restart_last_dispense <= 1'h0;
      end else begin
         auto_start_q          <= power_up & pfail_q & was_running_nv & ~keys_held_at_power;
         restart_last_dispense <= power_up & pfail_q & was_running_nv & ~keys_held_at_power
                                  & dispense_mode;
         restart_first_phase   <= power_up & pfail_q & was_running_nv & ~keys_held_at_power
                                  & ~dispense_mode;
      end
   end

   // ----------------------------------------------------------------
   // Outputs: motor, direction, anti-drip, slow-down
   // ----------------------------------------------------------------
   logic [VOL_W-1:0] remain;
   logic [VOL_W-1:0] drip_carry_q;

   assign remain = (target_vol > dispensed_vol) ? target_vol - dispensed_vol : '0;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         running       <= 1'h0;
         motor_active  <= 1'h0;
         withdraw      <= 1'h0;
         drip_withdraw <= 1'h0;
         drip_carry_q  <= '0;
         next_target   <= '0;
         speed_level   <= PTC_SPEED_FULL;
      end else begin
         running       <= ~stopped;
         motor_active  <= motor_mode_q ? (run_q != PTC_RUN_STOP)
                                       : (run_q == PTC_RUN_PUMP || run_q == PTC_RUN_DRIP);
         drip_withdraw <= (run_q == PTC_RUN_DRIP);
         if (run_q == PTC_RUN_DRIP && drip_done) begin
            drip_carry_q <= drip_vol;
         end else if (run_q == PTC_RUN_PUMP && volume_done && !withdraw) begin
            drip_carry_q <= '0;
         end
         next_target <= drip_en ? VOL_W'(target_vol + drip_carry_q) : target_vol;
         if (dir_mode_q == PTC_DIR_RECIP) begin
            if (dir_e.fall) withdraw <= 1'h0;
            if (dir_e.rise) withdraw <= 1'h1;
         end else begin
            if (dir_e.fall) withdraw <= 1'h1;
            if (dir_e.rise) withdraw <= 1'h0;
         end
         if (!slow_down_setting || target_vol == '0) begin
            speed_level <= PTC_SPEED_FULL;
         end else if (remain < (target_vol >> 4)) begin
            speed_level <= 2'h0;
         end else if (remain < (target_vol >> 3)) begin
            speed_level <= 2'h1;
         end else if (remain < (target_vol >> 2)) begin
            speed_level <= 2'h2;
         end else begin
            speed_level <= PTC_SPEED_FULL;
         end
      end
   end

   // ----------------------------------------------------------------
   // Buzzer
   // ----------------------------------------------------------------
   logic       silenced_q;
   logic       ended_q;
   logic       beep_ph_q;
   logic [1:0] beep_cnt_q;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         silenced_q <= 1'h0;
         ended_q    <= 1'h0;
         beep_ph_q  <= 1'h0;
         beep_cnt_q <= '0;
         buzzer     <= 1'h0;
      end else begin
         if (!stopped) begin
            ended_q <= 1'h0;
         end else if (run_q == PTC_RUN_STOP && running) begin
            ended_q <= 1'h1;
         end
         if (key_any) begin
            silenced_q <= 1'h1;
         end else if (start_req) begin
            silenced_q <= 1'h0;
         end
         if (tick) begin
            if (beep_cnt_q == 2'(PTC_BEEP_TENTHS - 1)) begin
               beep_cnt_q <= '0;
               beep_ph_q  <= ~beep_ph_q;
            end else begin
               beep_cnt_q <= beep_cnt_q + 2'h1;
            end
         end
         if (!alarm_en_q || silenced_q || key_any) begin
            buzzer <= 1'h0;
         end else if (alarm_cond) begin
            buzzer <= 1'h1;
         end else begin
            buzzer <= (ended_q | wait_trigger) & beep_ph_q;
         end
      end
   end
endmodule

/* ptc_top_sva.sv */
// Checker: concurrent assertions on the ports of the pump trigger control block
`timescale 1ns/100ps
module ptc_top_sva (
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic       set_wr,
   input wire logic [6:0] set_delay,
   input wire logic       power_up,
   input wire logic       keys_held_at_power,
   input wire logic       dispense_mode,
   input wire logic       running,
   input wire logic       motor_active,
   input wire logic       set_rejected,
   input wire logic [6:0] delay_val,
   input wire logic       repeat_en,
   input wire logic       slow_down_setting,
   input wire logic [1:0] speed_level,
   input wire logic       restart_first_phase,
   input wire logic       restart_last_dispense
);
   import ptc_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ------------------------------------------------------------
   // Run output and settings
   // ------------------------------------------------------------
   property p_motor_off; !running |-> !motor_active; endproperty
   a_motor_off: assert property (p_motor_off) else $error("motor output high while stopped");
   property p_reject; set_rejected |-> $past(set_wr) && running; endproperty
   a_reject: assert property (p_reject) else $error("set refused without cause");
   property p_delay_load;
      $changed(delay_val) |-> $past(set_wr) && !running && delay_val == $past(set_delay);
   endproperty
   a_delay_load: assert property (p_delay_load) else $error("delay changed without load");
   property p_opt_load; $changed(repeat_en) || $changed(slow_down_setting) |-> $past(set_wr) && !running; endproperty
   a_opt_load: assert property (p_opt_load) else $error("option changed while running");
   property p_speed_full;
      !slow_down_setting && !$past(slow_down_setting) |-> speed_level == PTC_SPEED_FULL;
   endproperty
   a_speed_full: assert property (p_speed_full) else $error("speed reduced with slow down off");
   // ------------------------------------------------------------
   // Restart after power loss
   // ------------------------------------------------------------
   property p_restart_cancel; power_up && keys_held_at_power |=> !restart_first_phase && !restart_last_dispense;
   endproperty
   a_restart_cancel: assert property (p_restart_cancel) else $error("restart not cancelled by key");
   property p_restart_first; restart_first_phase |-> $past(power_up) && !$past(dispense_mode); endproperty
   a_restart_first: assert property (p_restart_first) else $error("first phase restart wrong");
   property p_restart_last; restart_last_dispense |-> $past(power_up) && $past(dispense_mode); endproperty
   a_restart_last: assert property (p_restart_last) else $error("last dispense restart wrong");
   property p_restart_run; restart_first_phase || restart_last_dispense |-> ##2 running; endproperty
   a_restart_run: assert property (p_restart_run) else $error("restart did not run");
   c_reject: cover property (set_rejected);
   c_restart: cover property (restart_first_phase);
   c_pause: cover property (running && !motor_active);
endmodule
bind ptc_top ptc_top_sva u_sva (.ref_clk, .rst, .set_wr, .set_delay, .power_up, .keys_held_at_power,
   .dispense_mode, .running, .motor_active, .set_rejected, .delay_val, .repeat_en, .slow_down_setting,
   .speed_level, .restart_first_phase, .restart_last_dispense);

/* ptc_io_partner.sv */
// Partner: foot switch and direction source on the logic connector
`timescale 1ns/100ps
module ptc_io_partner (
   input  wire logic ref_clk,
   output logic      trig_pin,
   output logic      dir_pin
);
   // Pulled-up contacts idle high between presses
   initial begin
      trig_pin = 1'b1;
      dir_pin  = 1'b1;
   end
   // Levels change just after a rising edge
   task automatic drive_trig(input logic v);
      @(posedge ref_clk);
      #1;
      trig_pin = v;
   endtask
   task automatic drive_dir(input logic v);
      @(posedge ref_clk);
      #1;
      dir_pin = v;
   endtask
endmodule

/* pump_trigger_io_control_bench.sv */
// Testbench: run control, trigger, direction, pause, restart, buzzer and setup menu
`timescale 1ns/100ps
module pump_trigger_io_control_bench;
   import ptc_pkg::*;
   localparam int TC = 10;
   localparam logic [9:0] KS = 10'h001, SS = 10'h002, PU = 10'h004, VD = 10'h008, DD = 10'h010,
      KA = 10'h020, KN = 10'h040, KU = 10'h080, AR = 10'h100, SR = 10'h200;
   logic         ref_clk, trig_pin, dir_pin, running, motor_active, withdraw, drip_withdraw;
   logic         restart_first_phase, restart_last_dispense, buzzer, set_rejected, slow_down_setting;
   logic         drip_en, repeat_en, delay_tenths;
   logic         key_start, serial_run, serial_stop, key_any, key_setup, key_arrow, key_nonarrow;
   logic         power_up, volume_done, drip_done;
   logic         rst = 1'b1, keys_held_at_power = 1'b0, was_running_nv = 1'b0, dispense_mode = 1'b0;
   logic         wait_trigger = 1'b0, alarm_cond = 1'b0, set_wr = 1'b0, set_slow = 1'b0, set_drip = 1'b0;
   logic         set_repeat = 1'b0, set_delay_tenths = 1'b0, set_pfail = 1'b0, set_alarm = 1'b0;
   logic         set_motor_mode = 1'b0;
   logic [6:0]   set_delay = 7'h01;
   logic [6:0]   delay_val;
   logic [9:0]   pv = 10'h000;
   logic [15:0]  target_vol = 16'h0000, dispensed_vol = 16'h0000, drip_vol = 16'h0000, next_target;
   logic [1:0]   speed_level;
   ptc_trig_e    set_trig = PTC_TRG_TOGGLE;
   ptc_dirmode_e set_dir = PTC_DIR_RECIP;
   ptc_opt_e     setup_option;
   logic [4:0]   tt [8] = '{5'b01100, 5'b01010, 5'b00110, 5'b00101, 5'b01111, 5'b00111, 5'b10000, 5'b11000};
   logic [6:0]   dv [3] = '{7'h00, 7'h64, 7'h63};
   logic [6:0]   de [3] = '{7'h02, 7'h02, 7'h63};
   int           n_fail = 0;
   int           check_count = 0;
   int           beep_hi = 0;
   assign {serial_run, key_arrow, key_setup, key_nonarrow, key_any, drip_done, volume_done, power_up,
      serial_stop, key_start} = pv;
   ptc_top #(.TENTH_CYC(TC)) dut (.ref_clk, .rst, .trig_pin, .dir_pin, .key_start, .serial_run, .serial_stop,
      .key_any, .key_setup, .key_arrow, .key_nonarrow, .power_up, .keys_held_at_power, .was_running_nv,
      .dispense_mode, .volume_done, .drip_done, .wait_trigger, .alarm_cond, .target_vol, .dispensed_vol,
      .drip_vol, .set_wr, .set_slow, .set_drip, .set_repeat, .set_delay, .set_delay_tenths, .set_pfail,
      .set_alarm, .set_trig, .set_dir, .set_motor_mode, .running, .motor_active, .withdraw, .drip_withdraw,
      .next_target, .speed_level, .restart_first_phase, .restart_last_dispense, .buzzer, .setup_option,
      .set_rejected, .slow_down_setting, .drip_en, .repeat_en, .delay_val, .delay_tenths);
   ptc_io_partner part (.ref_clk, .trig_pin, .dir_pin);
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic clk(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic pulse(input logic [9:0] m);
      pv = m;
      clk(1);
      pv = 10'h000;
      clk(3);
   endtask
   task automatic wr;
      set_wr = 1'b1;
      clk(1);
      set_wr = 1'b0;
      clk(2);
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      if (n_fail == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      #100000;
      n_fail++;
      tally_and_finish();
   end
   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      clk(3);
      rst = 1'b0;
      clk(4);
      for (int m = 0; m < 8; m++) begin
         pulse(SS);
         set_trig = ptc_trig_e'(m);
         wr();
         if (tt[m][4]) pulse(SR);
         check("run_init", 16'(running), 16'(tt[m][4]));
         for (int e = 3; e >= 0; e--) begin
            part.drive_trig(~e[0]);
            clk(6);
            check("run_trig", 16'(running), 16'(tt[m][e]));
         end
      end
      for (int d = 0; d < 2; d++) begin
         set_dir = ptc_dirmode_e'(d);
         wr();
         part.drive_dir(1'b0);
         clk(6);
         check("withdraw_fall", 16'(withdraw), 16'(d));
         part.drive_dir(1'b1);
         clk(6);
         check("withdraw_rise", 16'(withdraw), 16'(d == 0));
      end
      set_trig = PTC_TRG_TOGGLE;
      set_repeat = 1'b1;
      set_delay_tenths = 1'b1;
      for (int m = 0; m < 2; m++) begin
         set_delay = 7'h02;
         set_motor_mode = m[0];
         wr();
         pulse(KS);
         check("motor_pump", 16'(motor_active), 16'h0001);
         pulse(VD);
         check("motor_pause", 16'(motor_active), 16'(m));
         check("run_pause", 16'(running), 16'h0001);
         clk(30);
         check("motor_repeat", 16'(motor_active), 16'h0001);
         set_delay = 7'h00;
         set_wr = 1'b1;
         clk(1);
         check("rejected", 16'(set_rejected), 16'h0001);
         set_wr = 1'b0;
         pulse(SS);
      end
      for (int i = 0; i < 3; i++) begin
         set_delay = dv[i];
         wr();
         check("delay_val", 16'(delay_val), 16'(de[i]));
      end
      check("delay_tenths", 16'(delay_tenths), 16'h0001);
      set_repeat = 1'b0;
      set_drip = 1'b1;
      wr();
      check("drip_en", 16'(drip_en), 16'h0001);
      target_vol = 16'h0100;
      drip_vol = 16'h0010;
      pulse(KS);
      pulse(VD);
      check("drip_withdraw", 16'(drip_withdraw), 16'h0001);
      pulse(DD);
      check("next_target", next_target, 16'h0110);
      pulse(SS);
      set_drip = 1'b0;
      set_slow = 1'b1;
      wr();
      target_vol = 16'h0640;
      pulse(KS);
      check("speed_full", 16'(speed_level), 16'h0003);
      dispensed_vol = 16'h0500;
      clk(3);
      check("speed_step", 16'(speed_level), 16'h0002);
      dispensed_vol = 16'h060E;
      clk(3);
      check("speed_low", 16'(speed_level), 16'h0000);
      pulse(SS);
      set_pfail = 1'b1;
      wr();
      was_running_nv = 1'b1;
      for (int r = 0; r < 3; r++) begin
         keys_held_at_power = (r == 2);
         dispense_mode = (r == 0);
         pv = PU;
         clk(1);
         pv = 10'h000;
         check("restart_last", 16'(restart_last_dispense), 16'(r == 0));
         check("restart_first", 16'(restart_first_phase), 16'(r == 1));
         clk(3);
         check("run_restart", 16'(running), 16'(r != 2));
         pulse(SS);
      end
      set_alarm = 1'b1;
      wr();
      alarm_cond = 1'b1;
      clk(3);
      check("buzzer_alarm", 16'(buzzer), 16'h0001);
      pulse(KA);
      check("buzzer_quiet", 16'(buzzer), 16'h0000);
      alarm_cond = 1'b0;
      pulse(KS);
      pulse(SS);
      repeat (70) begin
         clk(1);
         beep_hi += buzzer;
      end
      check("buzzer_beep", 16'(beep_hi > 0 && beep_hi < 70), 16'h0001);
      set_repeat = 1'b1;
      wr();
      pulse(KU);
      pulse(KN);
      check("setup_next", 16'(setup_option), 16'(PTC_OPT_DRIP));
      pulse(AR);
      clk(205);
      check("setup_timeout", 16'(setup_option), 16'(PTC_OPT_REPEAT));
      tally_and_finish();
   end
endmodule
